// ---- rtl/rlr_reset_tree.sv ----
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module rlr_reset_tree (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reconfig_clk,
  input wire logic ext_delay_clock,
  input wire logic latency_clk,
  input wire logic mii_tx_clk,
  input wire logic mii_rx_clk,
  input wire logic gmii_tx_clk,
  input wire logic gmii_rx_clk,
  input wire logic global_rst_low,
  input wire logic tx_path_rst_low,
  input wire logic rx_path_rst_low,
  input wire logic ext_delay_meas_rst_low,
  input wire logic latency_rst_low,
  input wire logic reconfig_rst,
  input wire logic mii_tx_rst_low,
  input wire logic mii_rx_rst_low,
  input wire logic gmii_tx_rst_low,
  input wire logic gmii_rx_rst_low,
  input wire logic xcvr_tx_ready,
  input wire logic xcvr_rx_ready,
  output logic tx_soft_rst_low,
  output logic rx_soft_rst_low,
  output logic ext_delay_rst_low_sync,
  output logic latency_rst_low_sync,
  output logic reconfig_port_rst,
  output logic rate_ctrl_rst,
  output logic host_regs_rst_low,
  output logic mii_tx_rst_low_sync,
  output logic mii_rx_rst_low_sync,
  output logic gmii_tx_rst_low_sync,
  output logic gmii_rx_rst_low_sync,
  output logic startup_run,
  output logic user_init_req
);
  localparam int NSYNC = 10;

  logic [rlr_pkg::RLR_CTRL_W-1:0] ctrl;
  logic [rlr_pkg::RLR_CTRL_W-1:0] next_ctrl;
  logic [rlr_pkg::RLR_OPT_W-1:0] opts;
  logic [rlr_pkg::RLR_OPT_W-1:0] next_opts;
  logic dp_write;
  logic next_dp_write;
  logic [7:0] dp_addr;
  logic [7:0] next_dp_addr;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] tx_rdy_meta;
  logic [1:0] rx_rdy_meta;
  logic [1:0] next_tx_rdy_meta;
  logic [1:0] next_rx_rdy_meta;
  rlr_pkg::rlr_seq_t seq;
  rlr_pkg::rlr_seq_t next_seq;
  logic recfg_present;
  logic [NSYNC-1:0] arst_vec;
  logic [NSYNC-1:0] srst_vec;
  logic [NSYNC-1:0] clk_vec;
  // Cross-domain copies of options and status
  logic seq_rst_n;
  logic [1:0] opt_startup_sync;
  logic [1:0] next_opt_startup_sync;
  logic [1:0] opt_oldproc_sync;
  logic [1:0] next_opt_oldproc_sync;
  logic [8:0] stat_meta;
  logic [8:0] next_stat_meta;
  logic [8:0] stat_sync;
  logic [8:0] next_stat_sync;

  // Register select by byte offset
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Valid address phase addressed to this slave
  function automatic logic is_addr_phase(input logic sel, input logic rdy, input logic [1:0] trans);
    return sel & rdy & trans[1];
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [9:0] c, input logic [5:0] o,
                                         input logic [10:0] s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (reg_hit(a, rlr_pkg::RLR_CTRL_OFS)) begin
      v = {22'h00_0000, c};
    end else if (reg_hit(a, rlr_pkg::RLR_STATUS_OFS)) begin
      v = {21'h00_0000, s};
    end else if (reg_hit(a, rlr_pkg::RLR_OPTS_OFS)) begin
      v = {26'h000_0000, o};
    end
    return v;
  endfunction

  // Presence of the reconfiguration reset by variant
  always_comb begin
    if (opts[rlr_pkg::RLR_OPT_MAINDEV]) begin
      recfg_present = opts[rlr_pkg::RLR_OPT_STARTUP] | opts[rlr_pkg::RLR_OPT_DEBUG] |
                      opts[rlr_pkg::RLR_OPT_AUTONEG] | opts[rlr_pkg::RLR_OPT_STDC];
    end else begin
      recfg_present = opts[rlr_pkg::RLR_OPT_AUTONEG] | opts[rlr_pkg::RLR_OPT_STARTUP];
    end
  end

  // Raw asynchronous reset sources per domain; global reset joins tx/rx only
  always_comb begin
    arst_vec[0] = global_rst_low & tx_path_rst_low & ~ctrl[rlr_pkg::RLR_CTRL_TX] &
                  ~ctrl[rlr_pkg::RLR_CTRL_GLOBAL];
    arst_vec[1] = global_rst_low & rx_path_rst_low & ~ctrl[rlr_pkg::RLR_CTRL_RX] &
                  ~ctrl[rlr_pkg::RLR_CTRL_GLOBAL];
    arst_vec[2] = ext_delay_meas_rst_low & ~ctrl[rlr_pkg::RLR_CTRL_EXTD];
    arst_vec[3] = latency_rst_low & ~ctrl[rlr_pkg::RLR_CTRL_LAT];
    arst_vec[4] = ~((reconfig_rst | ctrl[rlr_pkg::RLR_CTRL_RECFG]) & recfg_present);
    arst_vec[5] = hresetn;
    arst_vec[6] = mii_tx_rst_low & ~ctrl[rlr_pkg::RLR_CTRL_MIITX];
    arst_vec[7] = mii_rx_rst_low & ~ctrl[rlr_pkg::RLR_CTRL_MIIRX];
    arst_vec[8] = gmii_tx_rst_low & ~ctrl[rlr_pkg::RLR_CTRL_GMIITX];
    arst_vec[9] = gmii_rx_rst_low & ~ctrl[rlr_pkg::RLR_CTRL_GMIIRX];
  end

  // One clock per synchroniser slot, same order as the reset sources
  assign clk_vec = {gmii_rx_clk, gmii_tx_clk, mii_rx_clk, mii_tx_clk, hclk,
                    reconfig_clk, latency_clk, ext_delay_clock, reconfig_clk, reconfig_clk};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      rlr_sync_if sif ();
      assign sif.arst_n = arst_vec[gi];
      assign srst_vec[gi] = sif.srst_n;
      rlr_rst_sync u_sync (
        .clk(clk_vec[gi]),
        .rs(sif.dst)
      );
    end
  endgenerate

  assign tx_soft_rst_low = srst_vec[0];
  assign rx_soft_rst_low = srst_vec[1];
  assign ext_delay_rst_low_sync = srst_vec[2];
  assign latency_rst_low_sync = srst_vec[3];
  assign reconfig_port_rst = ~srst_vec[4];
  assign rate_ctrl_rst = ~srst_vec[4] & opt_oldproc_sync[1];
  assign host_regs_rst_low = srst_vec[5];
  assign mii_tx_rst_low_sync = srst_vec[6];
  assign mii_rx_rst_low_sync = srst_vec[7];
  assign gmii_tx_rst_low_sync = srst_vec[8];
  assign gmii_rx_rst_low_sync = srst_vec[9];

  // AHB-Lite slave: zero wait states, always OKAY
  always_comb begin
    next_dp_write = is_addr_phase(hsel, hready, htrans) & hwrite;
    next_dp_addr = is_addr_phase(hsel, hready, htrans) ? haddr[7:0] : dp_addr;
    next_ctrl = ctrl;
    next_opts = opts;
    if (dp_write && reg_hit(dp_addr, rlr_pkg::RLR_CTRL_OFS)) begin
      next_ctrl = hwdata[rlr_pkg::RLR_CTRL_W-1:0];
    end else if (dp_write && reg_hit(dp_addr, rlr_pkg::RLR_OPTS_OFS)) begin
      next_opts = hwdata[rlr_pkg::RLR_OPT_W-1:0];
    end
    next_rdata = rdata;
    if (is_addr_phase(hsel, hready, htrans) && !hwrite) begin
      next_rdata = rd_mux(haddr[7:0], next_ctrl, next_opts, {recfg_present, stat_sync, 1'b1});
    end
  end

  // CSR state only cleared by the host-port reset, not the global one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= rlr_pkg::RLR_CTRL_RST;
      opts <= rlr_pkg::RLR_OPTS_RST;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      opts <= next_opts;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      rdata <= next_rdata;
    end
  end

  assign hrdata = rdata;
  // Zero wait states, response always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Status from other clock domains passes two bus-clock flops before any read
  always_comb begin
    next_stat_meta = {startup_run, user_init_req, tx_rdy_meta[1], rx_rdy_meta[1], srst_vec[4],
                      srst_vec[3], srst_vec[2], srst_vec[1], srst_vec[0]};
    next_stat_sync = stat_meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_meta <= 9'h000;
      stat_sync <= 9'h000;
    end else begin
      stat_meta <= next_stat_meta;
      stat_sync <= next_stat_sync;
    end
  end

  // Transceiver ready inputs cross into reconfiguration clock
  always_comb begin
    next_tx_rdy_meta = {tx_rdy_meta[0], xcvr_tx_ready};
    next_rx_rdy_meta = {rx_rdy_meta[0], xcvr_rx_ready};
  end

  always_ff @(posedge reconfig_clk or negedge srst_vec[0]) begin
    if (!srst_vec[0]) begin
      tx_rdy_meta <= 2'h0;
    end else begin
      tx_rdy_meta <= next_tx_rdy_meta;
    end
  end

  always_ff @(posedge reconfig_clk or negedge srst_vec[1]) begin
    if (!srst_vec[1]) begin
      rx_rdy_meta <= 2'h0;
    end else begin
      rx_rdy_meta <= next_rx_rdy_meta;
    end
  end

  // Post-reset sequencing: wait both ready, then startup or hand to user
  always_comb begin
    next_seq = seq;
    case (seq)
      rlr_pkg::RLR_SEQ_HELD: begin
        next_seq = rlr_pkg::RLR_SEQ_WAIT_READY;
      end
      rlr_pkg::RLR_SEQ_WAIT_READY: begin
        if (tx_rdy_meta[1] && rx_rdy_meta[1]) begin
          next_seq = opt_startup_sync[1] ? rlr_pkg::RLR_SEQ_STARTUP : rlr_pkg::RLR_SEQ_USER;
        end
      end
      default: begin
        if (!tx_rdy_meta[1] || !rx_rdy_meta[1]) begin
          next_seq = rlr_pkg::RLR_SEQ_WAIT_READY;
        end
      end
    endcase
  end

  // Sequencer drops its outputs at once with a tx or rx path reset, or a reconfig reset when the variant has one
  assign seq_rst_n = srst_vec[4] & srst_vec[0] & srst_vec[1];

  always_ff @(posedge reconfig_clk or negedge seq_rst_n) begin
    if (!seq_rst_n) begin
      seq <= rlr_pkg::RLR_SEQ_HELD;
    end else begin
      seq <= next_seq;
    end
  end

  // Option bits cross from the bus clock into the reconfiguration clock
  always_comb begin
    next_opt_startup_sync = {opt_startup_sync[0], opts[rlr_pkg::RLR_OPT_STARTUP]};
    next_opt_oldproc_sync = {opt_oldproc_sync[0], opts[rlr_pkg::RLR_OPT_OLDPROC]};
  end

  always_ff @(posedge reconfig_clk) begin
    opt_startup_sync <= next_opt_startup_sync;
    opt_oldproc_sync <= next_opt_oldproc_sync;
  end

  assign startup_run = (seq == rlr_pkg::RLR_SEQ_STARTUP);
  assign user_init_req = (seq == rlr_pkg::RLR_SEQ_USER);
endmodule

// ---- shared/rlr_pkg.sv ----
package rlr_pkg;
  // Register byte offsets
  localparam logic [7:0] RLR_CTRL_OFS = 8'h00;
  localparam logic [7:0] RLR_STATUS_OFS = 8'h04;
  localparam logic [7:0] RLR_OPTS_OFS = 8'h08;
  // Control field positions
  localparam int RLR_CTRL_GLOBAL = 0;
  localparam int RLR_CTRL_TX = 1;
  localparam int RLR_CTRL_RX = 2;
  localparam int RLR_CTRL_EXTD = 3;
  localparam int RLR_CTRL_LAT = 4;
  localparam int RLR_CTRL_RECFG = 5;
  localparam int RLR_CTRL_MIITX = 6;
  localparam int RLR_CTRL_MIIRX = 7;
  localparam int RLR_CTRL_GMIITX = 8;
  localparam int RLR_CTRL_GMIIRX = 9;
  localparam int RLR_CTRL_W = 10;
  localparam logic [9:0] RLR_CTRL_RST = 10'h000;
  // Option field positions
  localparam int RLR_OPT_STARTUP = 0;
  localparam int RLR_OPT_DEBUG = 1;
  localparam int RLR_OPT_AUTONEG = 2;
  localparam int RLR_OPT_STDC = 3;
  localparam int RLR_OPT_MAINDEV = 4;
  localparam int RLR_OPT_OLDPROC = 5;
  localparam int RLR_OPT_W = 6;
  localparam logic [5:0] RLR_OPTS_RST = 6'h11;
  // Synchroniser depth
  localparam int RLR_SYNC_STAGES = 2;
  typedef enum logic [1:0] {RLR_SEQ_HELD, RLR_SEQ_WAIT_READY, RLR_SEQ_STARTUP, RLR_SEQ_USER} rlr_seq_t;
endpackage

// ---- shared/rlr_sync_if.sv ----
`timescale 1ns/1ps
interface rlr_sync_if;
  logic arst_n;
  logic srst_n;
  modport src (output arst_n, input srst_n);
  modport dst (input arst_n, output srst_n);
endinterface

// ---- rtl/rlr_rst_sync.sv ----
`timescale 1ns/1ps
module rlr_rst_sync (
  input wire logic clk,
  rlr_sync_if.dst rs
);
  logic [rlr_pkg::RLR_SYNC_STAGES-1:0] stages;
  logic [rlr_pkg::RLR_SYNC_STAGES-1:0] next_stages;

  always_comb begin
    next_stages = {stages[rlr_pkg::RLR_SYNC_STAGES-2:0], 1'b1};
  end

  // Assert at once, release on a clock edge
  always_ff @(posedge clk or negedge rs.arst_n) begin
    if (!rs.arst_n) begin
      stages <= '0;
    end else begin
      stages <= next_stages;
    end
  end

  assign rs.srst_n = stages[rlr_pkg::RLR_SYNC_STAGES-1];
endmodule

// ---- test/rlr_xcvr_seq_model.sv ----
`timescale 1ns/1ps
module rlr_xcvr_seq_model (
  input wire logic clk,
  input wire logic trig_low,
  input wire logic [7:0] settle,
  output logic ready
);
  logic [7:0] cnt;
  // Ready drops on trigger, rises on the settle+1th clock edge after the trigger is released
  always_ff @(posedge clk or negedge trig_low) begin
    if (!trig_low) begin
      cnt <= 8'h00;
      ready <= 1'b0;
    end else if (cnt < settle) begin
      cnt <= cnt + 8'h01;
    end else begin
      ready <= 1'b1;
    end
  end
endmodule

// ---- test/rlr_reset_tree_assertions.sv ----
`timescale 1ns/1ps
module rlr_reset_tree_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reconfig_clk,
  input wire logic global_rst_low,
  input wire logic tx_path_rst_low,
  input wire logic rx_path_rst_low,
  input wire logic reconfig_rst,
  input wire logic tx_soft_rst_low,
  input wire logic rx_soft_rst_low,
  input wire logic reconfig_port_rst,
  input wire logic rate_ctrl_rst,
  input wire logic host_regs_rst_low,
  input wire logic startup_run,
  input wire logic user_init_req
);
  property p_glob;
    @(posedge reconfig_clk) disable iff (reconfig_rst) !global_rst_low |-> !tx_soft_rst_low && !rx_soft_rst_low;
  endproperty
  a_glob: assert property (p_glob) else $error("global reset missed");
  property p_tx;
    @(posedge reconfig_clk) disable iff (reconfig_rst) !tx_path_rst_low |-> !tx_soft_rst_low;
  endproperty
  a_tx: assert property (p_tx) else $error("tx reset missed");
  property p_rx;
    @(posedge reconfig_clk) disable iff (reconfig_rst) !rx_path_rst_low |-> !rx_soft_rst_low;
  endproperty
  a_rx: assert property (p_rx) else $error("rx reset missed");
  property p_tx_rel;
    @(posedge reconfig_clk) disable iff (reconfig_rst)
      $rose(tx_soft_rst_low) |-> $past(tx_path_rst_low) && $past(global_rst_low);
  endproperty
  a_tx_rel: assert property (p_tx_rel) else $error("tx release early");
  property p_rate;
    @(posedge reconfig_clk) disable iff (!global_rst_low) rate_ctrl_rst |-> reconfig_port_rst;
  endproperty
  a_rate: assert property (p_rate) else $error("rate reset alone");
  property p_rcfg_rel;
    @(posedge reconfig_clk) disable iff (!global_rst_low) $fell(reconfig_port_rst) |-> !$past(reconfig_rst);
  endproperty
  a_rcfg_rel: assert property (p_rcfg_rel) else $error("reconfig release early");
  property p_seq;
    @(posedge reconfig_clk) disable iff (reconfig_rst) (startup_run || user_init_req) |->
      tx_soft_rst_low && rx_soft_rst_low && !(startup_run && user_init_req);
  endproperty
  a_seq: assert property (p_seq) else $error("init while held");
  property p_host;
    @(posedge hclk) disable iff (!hresetn) $rose(host_regs_rst_low) |-> $past(hresetn);
  endproperty
  a_host: assert property (p_host) else $error("host release early");
  c_start: cover property (@(posedge reconfig_clk) startup_run);
  c_user: cover property (@(posedge reconfig_clk) user_init_req);
  c_rate: cover property (@(posedge reconfig_clk) rate_ctrl_rst);
endmodule
bind rlr_reset_tree rlr_reset_tree_assertions rlr_reset_tree_assertions_i (
  .hclk(hclk),
  .hresetn(hresetn),
  .reconfig_clk(reconfig_clk),
  .global_rst_low(global_rst_low),
  .tx_path_rst_low(tx_path_rst_low),
  .rx_path_rst_low(rx_path_rst_low),
  .reconfig_rst(reconfig_rst),
  .tx_soft_rst_low(tx_soft_rst_low),
  .rx_soft_rst_low(rx_soft_rst_low),
  .reconfig_port_rst(reconfig_port_rst),
  .rate_ctrl_rst(rate_ctrl_rst),
  .host_regs_rst_low(host_regs_rst_low),
  .startup_run(startup_run),
  .user_init_req(user_init_req)
);

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, global_rst_low, tx_path_rst_low, rx_path_rst_low, reconfig_rst;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, r;
  logic [5:0] dom_src;
  logic [6:0] dom_clk;
  logic [6:0] tab [10] = '{7'h10, 7'h52, 7'h58, 7'h51, 7'h00, 7'h02, 7'h44, 7'h41, 7'h64, 7'h30};
  wire logic [5:0] dom_out;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, tx_ready, rx_ready, tx_soft_rst_low, rx_soft_rst_low, reconfig_port_rst;
  wire logic rate_ctrl_rst, host_regs_rst_low, startup_run, user_init_req;
  int n_mismatch = 0;
  int check_count = 0;
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  for (genvar g = 0; g < 7; g++) begin : gen_clk
    initial begin
      dom_clk[g] = 1'b0;
      forever #(4 + g) dom_clk[g] = ~dom_clk[g];
    end
  end
  rlr_reset_tree rlr_reset_tree_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reconfig_clk(dom_clk[6]), .ext_delay_clock(dom_clk[0]), .latency_clk(dom_clk[1]),
    .mii_tx_clk(dom_clk[2]), .mii_rx_clk(dom_clk[3]), .gmii_tx_clk(dom_clk[4]), .gmii_rx_clk(dom_clk[5]),
    .global_rst_low(global_rst_low), .tx_path_rst_low(tx_path_rst_low), .rx_path_rst_low(rx_path_rst_low),
    .ext_delay_meas_rst_low(dom_src[0]), .latency_rst_low(dom_src[1]), .reconfig_rst(reconfig_rst),
    .mii_tx_rst_low(dom_src[2]), .mii_rx_rst_low(dom_src[3]), .gmii_tx_rst_low(dom_src[4]),
    .gmii_rx_rst_low(dom_src[5]), .xcvr_tx_ready(tx_ready), .xcvr_rx_ready(rx_ready),
    .tx_soft_rst_low(tx_soft_rst_low), .rx_soft_rst_low(rx_soft_rst_low), .ext_delay_rst_low_sync(dom_out[0]),
    .latency_rst_low_sync(dom_out[1]), .reconfig_port_rst(reconfig_port_rst), .rate_ctrl_rst(rate_ctrl_rst),
    .host_regs_rst_low(host_regs_rst_low), .mii_tx_rst_low_sync(dom_out[2]), .mii_rx_rst_low_sync(dom_out[3]),
    .gmii_tx_rst_low_sync(dom_out[4]), .gmii_rx_rst_low_sync(dom_out[5]), .startup_run(startup_run),
    .user_init_req(user_init_req));
  // Sequencers triggered from the core path reset source
  rlr_xcvr_seq_model tx_seq_i (.clk(dom_clk[6]), .trig_low(tx_path_rst_low & global_rst_low), .settle(8'h03),
    .ready(tx_ready));
  rlr_xcvr_seq_model rx_seq_i (.clk(dom_clk[6]), .trig_low(rx_path_rst_low & global_rst_low), .settle(8'h28),
    .ready(rx_ready));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, exp, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic poll(input logic [31:0] exp);
    int k = 0;
    do begin
      xfer(rlr_pkg::RLR_STATUS_OFS, 1'b0, 32'h0);
      k++;
    end while (k < 100 && r !== exp);
    chk("status", exp, r);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, global_rst_low, tx_path_rst_low, rx_path_rst_low} = 6'h00;
    {reconfig_rst, dom_src, htrans, haddr, hwdata, r} = '0;
    reconfig_rst = 1'b1;
    repeat (10) @(posedge hclk);
    {hresetn, hsel, global_rst_low, tx_path_rst_low, rx_path_rst_low} <= 5'h1F;
    reconfig_rst <= 1'b0;
    dom_src <= 6'h3F;
    @(posedge hclk);
    rd(rlr_pkg::RLR_CTRL_OFS, 32'h0, "ctrl");
    rd(rlr_pkg::RLR_OPTS_OFS, 32'h11, "opts");
    rd(8'h0C, 32'h0, "unmapped");
    poll(32'h6FF);
    $display("reset values test done");
    xfer(rlr_pkg::RLR_OPTS_OFS, 1'b1, 32'h14);
    global_rst_low <= 1'b0;
    repeat (3) @(posedge dom_clk[6]);
    #1;
    chk("global", 32'h13F, {tx_soft_rst_low, rx_soft_rst_low, host_regs_rst_low, startup_run, user_init_req, dom_out});
    @(posedge hclk);
    global_rst_low <= 1'b1;
    poll(32'h5FF);
    rd(rlr_pkg::RLR_OPTS_OFS, 32'h14, "opts kept");
    for (int p = 0; p < 2; p++) begin
      tx_path_rst_low <= p[0];
      rx_path_rst_low <= !p[0];
      repeat (3) @(posedge dom_clk[6]);
      #1;
      chk("path", {30'h0, p[0], !p[0]}, {30'h0, tx_soft_rst_low, rx_soft_rst_low});
      @(posedge hclk);
      {tx_path_rst_low, rx_path_rst_low} <= 2'h3;
      poll(32'h5FF);
    end
    $display("global and path test done");
    foreach (tab[i]) begin
      xfer(rlr_pkg::RLR_OPTS_OFS, 1'b1, {26'h0, tab[i][5:0]});
      reconfig_rst <= 1'b1;
      repeat (4) @(posedge dom_clk[6]);
      #1;
      chk("reconfig", {tab[i][6], tab[i][6] & tab[i][5]}, {reconfig_port_rst, rate_ctrl_rst});
      @(posedge hclk);
      xfer(rlr_pkg::RLR_STATUS_OFS, 1'b0, 32'h0);
      chk("present", tab[i][6], r[10]);
      reconfig_rst <= 1'b0;
    end
    $display("reconfig test done");
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    chk("host", 32'h0, host_regs_rst_low);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(rlr_pkg::RLR_OPTS_OFS, 32'h11, "opts cleared");
    for (int i = 0; i < 6; i++) begin
      dom_src[i] <= 1'b0;
      repeat (2) @(posedge dom_clk[i]);
      #1;
      chk("domain", 6'h3F ^ (6'h01 << i), dom_out);
      @(posedge hclk);
      dom_src[i] <= 1'b1;
      repeat (3) @(posedge dom_clk[i]);
      #1;
      chk("domain release", 32'h3F, dom_out);
      @(posedge hclk);
    end
    $display("domain test done");
    xfer(rlr_pkg::RLR_CTRL_OFS, 1'b1, 32'h3F9);
    repeat (2) @(posedge hclk);
    #1;
    chk("ctrl path", 32'hC, {host_regs_rst_low, reconfig_port_rst, tx_soft_rst_low, rx_soft_rst_low});
    chk("ctrl domains", 32'h0, dom_out);
    @(posedge hclk);
    rd(rlr_pkg::RLR_CTRL_OFS, 32'h3F9, "ctrl");
    xfer(rlr_pkg::RLR_CTRL_OFS, 1'b1, 32'h0);
    poll(32'h6FF);
    chk("ctrl release", 32'h3F, {reconfig_port_rst, dom_out});
    $display("control test done");
    conclude();
  end
  initial begin
    #400000;
    n_mismatch++;
    $display("watchdog expired");
    conclude();
  end
endmodule
